// ==== core/sucal_bank.sv ====
// user calibration register bank with correction datapath and flash save sequencing
//
// Notes on behaviour
// [R1] accel offsets: 14-bit signed in bits 13:0, 0.25 mg/LSB, reset zero.
// [R2] accel offset added to measurement just before loading accel result register.
// [R3] each axis correction summed into data right before its output register.
// [R4] mag hard-iron: 14-bit signed in bits 13:0, 0.5 mgauss/LSB, added.
// [R5] hard-iron registers reset to 0x0800; top two bits unused.
// [R6] soft-iron: unsigned 12-bit gain, 0x800 unity, 0xFFF about two.
// [R7] misc control bit 6 enables point-of-percussion translation of accel data.
// [R8] correction values stay volatile until an explicit save to flash.
// [R9] global command bit 3 copies all corrections into flash.
// [R10] global command bit 1 clears rate and accel offsets, zeroes outputs.
// [R11] after restore, flash written within 75 ms, then sampling resumes.
// [R12] host limits how often it saves, minding flash endurance.
// [R13] host negates bias estimate and encodes it before writing.
// [R14] host derives soft-iron code as gain halved times 4095.
// [R15] 16-bit register written upper byte at odd address, then lower byte.
`timescale 1ns/1ps
module sucal_bank
	import sucal_pkg::*;
#(
	parameter int unsigned FLASH_TIMEOUT_CYC = FLASH_LIMIT_CYC
)
(
	input  wire logic                core_clk,
	input  wire logic                rstn,
	input  wire logic                frameValid,
	input  wire logic                frameWrite,
	input  wire logic [6:0]          frameAddr,
	input  wire logic [7:0]          frameData,
	output logic      [15:0]         readData,
	output logic                     readValid,
	input  wire logic                sampleValid,
	input  wire logic signed [15:0]  rawAccelX,
	input  wire logic signed [15:0]  rawAccelY,
	input  wire logic signed [15:0]  rawAccelZ,
	input  wire logic signed [15:0]  popAccelX,
	input  wire logic signed [15:0]  popAccelY,
	input  wire logic signed [15:0]  popAccelZ,
	input  wire logic signed [15:0]  rawMagX,
	input  wire logic signed [15:0]  rawMagY,
	input  wire logic signed [15:0]  rawMagZ,
	output logic signed [15:0]       accelXResult,
	output logic signed [15:0]       accelYResult,
	output logic signed [15:0]       accelZResult,
	output logic signed [15:0]       magXResult,
	output logic signed [15:0]       magYResult,
	output logic signed [15:0]       magZResult,
	output logic                     resultValid,
	output logic                     samplingActive,
	output logic                     rateOffsetClear,
	output logic                     flashWordValid,
	output logic      [3:0]          flashWordIndex,
	output logic      [15:0]         flashWord,
	output logic                     flashCommit,
	input  wire logic                flashDone,
	output logic                     cmdBusy
);

	// the wait counter cannot serve a zero-cycle bound
	if (FLASH_TIMEOUT_CYC < 1)
	begin : gBadTimeout
		$error("FLASH_TIMEOUT_CYC must be at least one cycle");
	end

	////////////////////////////////////////////////////////////////////////////
	// storage

	logic [13:0]  accelOffset [NAXES];
	logic [13:0]  hardIron    [NAXES];
	logic [11:0]  softIron    [NAXES];
	logic         popEnable;
	sucal_state_t state;
	logic         restoring;
	logic [3:0]   sendIndex;
	logic [31:0]  waitCount;

	logic         writeHit;
	logic         upperByte;
	logic [6:0]   evenAddr;
	logic         doSave;
	logic         doRestore;
	logic         waitDone;

	always_comb
	begin
		// shared by the sequencer and the sampling flag so both leave the wait together
		waitDone  = (state == ST_WAIT)
			&& (flashDone || waitCount == 32'(FLASH_TIMEOUT_CYC - 1));
		writeHit  = frameValid && frameWrite && (state == ST_IDLE);
		upperByte = frameAddr[0];
		evenAddr  = {frameAddr[6:1], 1'b0};
		doSave    = writeHit && !upperByte && (evenAddr == ADDR_GLOBAL_COMMAND)
			&& frameData[GCMD_SAVE_BIT];
		doRestore = writeHit && !upperByte && (evenAddr == ADDR_GLOBAL_COMMAND)
			&& frameData[GCMD_RESTORE_BIT];
	end

	////////////////////////////////////////////////////////////////////////////
	// register writes; plain flops, so values are lost at power down

	// [R8] volatile until saved
	always_ff @(posedge core_clk)
	begin
		if (!rstn)
		begin
			for (int i = 0; i < NAXES; i++)
			begin
				// [R1] accel offset reset
				accelOffset[i] <= ACCEL_OFFSET_RST[13:0];
				// [R5] hard-iron reset value
				hardIron[i]    <= HARD_IRON_RST[13:0];
				softIron[i]    <= SOFT_IRON_RST[11:0];
			end
			popEnable <= 1'b0;
		end
		else if (doRestore)
		begin
			// [R10] clear accel offsets
			for (int i = 0; i < NAXES; i++)
				accelOffset[i] <= ACCEL_OFFSET_RST[13:0];
		end
		else if (writeHit)
		begin
			for (int i = 0; i < NAXES; i++)
			begin
				// [R15] byte lane by address parity
				if (evenAddr == ADDR_ACCEL_X_OFFSET + 7'(ADDR_STEP * i))
				begin
					if (upperByte)
						accelOffset[i][13:8] <= frameData[5:0];
					else
						accelOffset[i][7:0] <= frameData;
				end
				else if (evenAddr == ADDR_MAG_X_HARD_IRON + 7'(ADDR_STEP * i))
				begin
					if (upperByte)
						hardIron[i][13:8] <= frameData[5:0];
					else
						hardIron[i][7:0] <= frameData;
				end
				else if (evenAddr == ADDR_MAG_X_SOFT_IRON + 7'(ADDR_STEP * i))
				begin
					if (upperByte)
						softIron[i][11:8] <= frameData[3:0];
					else
						softIron[i][7:0] <= frameData;
				end
			end
			// [R7] point-of-percussion enable
			if (evenAddr == ADDR_MISC_CONTROL && !upperByte)
				popEnable <= frameData[MISC_POP_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// register reads; unused bits and unmapped addresses read zero

	always_ff @(posedge core_clk)
	begin
		if (!rstn)
		begin
			readData  <= 16'h0000;
			readValid <= 1'b0;
		end
		else
		begin
			readValid <= frameValid && !frameWrite;
			if (frameValid && !frameWrite)
			begin
				readData <= 16'h0000;
				for (int i = 0; i < NAXES; i++)
				begin
					if (evenAddr == ADDR_ACCEL_X_OFFSET + 7'(ADDR_STEP * i))
						readData <= {2'b00, accelOffset[i]};
					else if (evenAddr == ADDR_MAG_X_HARD_IRON + 7'(ADDR_STEP * i))
						readData <= {2'b00, hardIron[i]};
					else if (evenAddr == ADDR_MAG_X_SOFT_IRON + 7'(ADDR_STEP * i))
						readData <= {4'h0, softIron[i]};
				end
				if (evenAddr == ADDR_MISC_CONTROL)
					readData <= 16'(popEnable) << MISC_POP_BIT;
				else if (evenAddr == ADDR_GLOBAL_COMMAND)
					readData <= 16'h0000;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// save and restore sequencing

	logic [15:0] imageWord;

	always_comb
	begin
		imageWord = 16'h0000;
		for (int i = 0; i < NAXES; i++)
		begin
			if (sendIndex == 4'(i))
				imageWord = {2'b00, accelOffset[i]};
			else if (sendIndex == 4'(i + NAXES))
				imageWord = {2'b00, hardIron[i]};
			else if (sendIndex == 4'(i + 2 * NAXES))
				imageWord = {4'h0, softIron[i]};
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!rstn)
		begin
			state           <= ST_IDLE;
			restoring       <= 1'b0;
			sendIndex       <= 4'h0;
			waitCount       <= 32'h00000000;
			flashWordValid  <= 1'b0;
			flashWordIndex  <= 4'h0;
			flashWord       <= 16'h0000;
			flashCommit     <= 1'b0;
			rateOffsetClear <= 1'b0;
		end
		else
		begin
			flashWordValid  <= 1'b0;
			rateOffsetClear <= 1'b0;
			case (state)
				ST_IDLE:
				begin
					// [R9] save command starts the image copy
					if (doSave || doRestore)
					begin
						state     <= ST_SEND;
						sendIndex <= 4'h0;
						restoring <= doRestore;
					end
					// [R10] rate offsets live outside, cleared by pulse
					rateOffsetClear <= doRestore;
				end
				ST_SEND:
				begin
					flashWordValid <= 1'b1;
					flashWordIndex <= sendIndex;
					flashWord      <= imageWord;
					sendIndex      <= sendIndex + 4'h1;
					if (sendIndex == FLASH_WORDS - 4'h1)
					begin
						state       <= ST_WAIT;
						flashCommit <= 1'b1;
						waitCount   <= 32'h00000000;
					end
				end
				ST_WAIT:
				begin
					waitCount <= waitCount + 32'h00000001;
					// [R11] flash done or 75 ms bound, then resume
					if (waitDone)
					begin
						state       <= ST_IDLE;
						flashCommit <= 1'b0;
						restoring   <= 1'b0;
					end
				end
				default:
					state <= ST_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// correction datapath

	logic signed [15:0] rawAll   [2 * NAXES];
	logic signed [15:0] extraAll [2 * NAXES];
	logic signed [15:0] corr     [2 * NAXES];

	always_comb
	begin
		rawAll[0]   = rawAccelX;
		rawAll[1]   = rawAccelY;
		rawAll[2]   = rawAccelZ;
		rawAll[3]   = rawMagX;
		rawAll[4]   = rawMagY;
		rawAll[5]   = rawMagZ;
		// [R7] lever-arm term only when enabled
		extraAll[0] = popEnable ? popAccelX : 16'sh0000;
		extraAll[1] = popEnable ? popAccelY : 16'sh0000;
		extraAll[2] = popEnable ? popAccelZ : 16'sh0000;
		extraAll[3] = 16'sh0000;
		extraAll[4] = 16'sh0000;
		extraAll[5] = 16'sh0000;
	end

	for (genvar a = 0; a < 2 * NAXES; a++)
	begin : gAxis
		// [R2] [R4] [R6] offset applied per axis, gain on the mag axes only
		sucal_axis uAxis (
			.raw     (rawAll[a]),
			.offset  (a < NAXES ? accelOffset[a % NAXES] : hardIron[a % NAXES]),
			.gain    (softIron[a % NAXES]),
			.useGain (a >= NAXES),
			.extra   (extraAll[a]),
			.result  (corr[a])
		);
	end

	// [R3] corrected sum loads the output registers directly
	always_ff @(posedge core_clk)
	begin
		if (!rstn || doRestore)
		begin
			// [R10] restore zeroes all output data
			accelXResult <= 16'sh0000;
			accelYResult <= 16'sh0000;
			accelZResult <= 16'sh0000;
			magXResult   <= 16'sh0000;
			magYResult   <= 16'sh0000;
			magZResult   <= 16'sh0000;
			resultValid  <= 1'b0;
		end
		else
		begin
			// samples arriving during a restore are dropped, outputs hold zero
			resultValid <= sampleValid && !restoring;
			if (sampleValid && !restoring)
			begin
				accelXResult <= corr[0];
				accelYResult <= corr[1];
				accelZResult <= corr[2];
				magXResult   <= corr[3];
				magYResult   <= corr[4];
				magZResult   <= corr[5];
			end
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!rstn)
		begin
			samplingActive <= 1'b0;
			cmdBusy        <= 1'b0;
		end
		else
		begin
			// rises at the edge where sample acceptance resumes, not one later
			samplingActive <= !(doRestore || (restoring && !waitDone));
			cmdBusy        <= (state != ST_IDLE) || doSave || doRestore;
		end
	end

endmodule // sucal_bank

// ==== core/sucal_pkg.sv ====
// shared constants and types of the user calibration register bank
package sucal_pkg;

	localparam int unsigned ADDR_W = 7;
	localparam int unsigned DATA_W = 16;
	localparam int unsigned OFS_W  = 14;
	localparam int unsigned GAIN_W = 12;
	localparam int unsigned NAXES  = 3;

	// byte addresses of the even (low) byte of each register
	localparam logic [6:0] ADDR_ACCEL_X_OFFSET  = 7'h24;
	localparam logic [6:0] ADDR_ACCEL_Y_OFFSET  = 7'h26;
	localparam logic [6:0] ADDR_ACCEL_Z_OFFSET  = 7'h28;
	localparam logic [6:0] ADDR_MAG_X_HARD_IRON = 7'h2a;
	localparam logic [6:0] ADDR_MAG_Y_HARD_IRON = 7'h2c;
	localparam logic [6:0] ADDR_MAG_Z_HARD_IRON = 7'h2e;
	localparam logic [6:0] ADDR_MAG_X_SOFT_IRON = 7'h30;
	localparam logic [6:0] ADDR_MAG_Y_SOFT_IRON = 7'h32;
	localparam logic [6:0] ADDR_MAG_Z_SOFT_IRON = 7'h34;
	localparam logic [6:0] ADDR_MISC_CONTROL    = 7'h38;
	localparam logic [6:0] ADDR_GLOBAL_COMMAND  = 7'h42;
	localparam logic [6:0] ADDR_STEP            = 7'h02;

	// field positions
	localparam int unsigned MISC_POP_BIT       = 6;
	localparam int unsigned GCMD_RESTORE_BIT   = 1;
	localparam int unsigned GCMD_SAVE_BIT      = 3;
	localparam int unsigned GAIN_UNITY_SHIFT   = 11;

	// reset values
	localparam logic [15:0] ACCEL_OFFSET_RST = 16'h0000;
	localparam logic [15:0] HARD_IRON_RST    = 16'h0800;
	localparam logic [15:0] SOFT_IRON_RST    = 16'h0000;

	// flash image: nine correction words, accel x..z, hard iron x..z, soft iron x..z
	localparam logic [3:0] FLASH_WORDS = 4'h9;

	// timing
	localparam int unsigned CLK_KHZ         = 250000;
	localparam int unsigned FLASH_LIMIT_MS  = 75;
	localparam int unsigned FLASH_LIMIT_CYC = FLASH_LIMIT_MS * CLK_KHZ;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_SEND,
		ST_WAIT
	} sucal_state_t;

endpackage

// ==== core/sucal_axis.sv ====
// correction datapath of one sensor axis: soft-iron gain, offset and lever-arm term
`timescale 1ns/1ps
module sucal_axis
	import sucal_pkg::*;
(
	input  wire logic signed [15:0] raw,
	input  wire logic        [13:0] offset,
	input  wire logic        [11:0] gain,
	input  wire logic               useGain,
	input  wire logic signed [15:0] extra,
	output logic signed      [15:0] result
);

	logic signed [28:0] product;
	logic signed [17:0] scaled;
	logic signed [19:0] sum;

	always_comb
	begin
		product = raw * $signed({1'b0, gain});
		// code 0x800 is unity, so the product is rescaled by the unity shift
		scaled  = useGain ? 18'(product >>> GAIN_UNITY_SHIFT) : 18'(raw);
		sum     = 20'(scaled) + 20'($signed(offset)) + 20'(extra);
		// clamp rather than wrap so a large correction cannot flip the sign
		if (sum > 20'sd32767)
			result = 16'sh7fff;
		else if (sum < -20'sd32768)
			result = 16'sh8000;
		else
			result = sum[15:0];
	end

endmodule // sucal_axis

// ==== verification/sucal_assertions.sv ====
// concurrent checks on the ports of the calibration bank
`timescale 1ns/1ps
module sucal_checker
	import sucal_pkg::*;
(
	input wire logic               core_clk,
	input wire logic               rstn,
	input wire logic               frameValid,
	input wire logic               frameWrite,
	input wire logic [6:0]         frameAddr,
	input wire logic [7:0]         frameData,
	input wire logic               readValid,
	input wire logic               sampleValid,
	input wire logic               resultValid,
	input wire logic signed [15:0] accelXResult,
	input wire logic               samplingActive,
	input wire logic               rateOffsetClear,
	input wire logic               flashWordValid,
	input wire logic [3:0]         flashWordIndex,
	input wire logic               flashCommit,
	input wire logic               cmdBusy
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rstn);
	logic cmdWr;
	// only the low byte of the command word acts, and only when idle
	assign cmdWr = frameValid && frameWrite && frameAddr == ADDR_GLOBAL_COMMAND && !cmdBusy;
	////////////////////////////////////////////////////////////
	a_read_answer: assert property (frameValid && !frameWrite |=> readValid)
		else $error("read frame not answered");
	a_read_quiet: assert property (!(frameValid && !frameWrite) |=> !readValid)
		else $error("read answer without frame");
	a_result_cause: assert property (resultValid |-> $past(sampleValid))
		else $error("result without sample");
	a_hold_samples: assert property (!samplingActive && sampleValid && $past(rstn) |=> !resultValid)
		else $error("sample taken during restore");
	a_restore_clear: assert property (cmdWr && frameData[GCMD_RESTORE_BIT] |=>
		rateOffsetClear && !samplingActive && accelXResult == 16'sh0000)
		else $error("restore did not clear");
	a_clear_pulse: assert property (rateOffsetClear |=> !rateOffsetClear)
		else $error("offset clear longer than one cycle");
	a_save_start: assert property (cmdWr && frameData[GCMD_SAVE_BIT] |=>
		cmdBusy ##1 flashWordValid && flashWordIndex == 4'h0)
		else $error("save did not start image");
	a_word_step: assert property (flashWordValid && flashWordIndex != 4'h8 |=>
		flashWordValid && flashWordIndex == $past(flashWordIndex) + 4'h1)
		else $error("image words not consecutive");
	a_last_commit: assert property (flashWordValid && flashWordIndex == 4'h8 |-> flashCommit)
		else $error("no commit with last word");
	a_flash_bound: assert property ($rose(flashCommit) |-> ##[1:60] !cmdBusy)
		else $error("flash write not finished in time");
	c_save: cover property (cmdWr && frameData[GCMD_SAVE_BIT]);
	c_restore: cover property (rateOffsetClear);
	c_result: cover property (resultValid);
endmodule // sucal_checker

bind sucal_bank sucal_checker i_chk (.*);

// ==== verification/sucal_host.sv ====
// host model: byte frames on the register port, plus a flash stand-in
`timescale 1ns/1ps
module sucal_host
(
	input  wire logic        core_clk,
	input  wire logic        flashCommit,
	input  wire logic        flashStall,
	input  wire logic [15:0] readData,
	output logic             frameValid = 1'b0,
	output logic             frameWrite = 1'b0,
	output logic [6:0]       frameAddr = 7'h00,
	output logic [7:0]       frameData = 8'h00,
	output logic             flashDone = 1'b0
);
	// a stalled flash never answers, which forces the sequencer timeout
	always @(posedge core_clk)
		flashDone <= flashCommit && !flashStall && !flashDone;
	////////////////////////////////////////////////////////////
	task automatic send(input logic wr, input logic [6:0] a, input logic [7:0] d);
		@(posedge core_clk);
		frameValid <= 1'b1;
		frameWrite <= wr;
		frameAddr <= a;
		frameData <= d;
	endtask
	// released address and data lines carry inverted leftovers; frameWrite keeps its stale value
	task automatic release_bus();
		@(posedge core_clk);
		frameValid <= 1'b0;
		frameAddr <= ~frameAddr;
		frameData <= ~frameData;
	endtask
	task automatic write_word(input logic [6:0] a, input logic [15:0] v);
		send(1'b1, a | 7'h01, v[15:8]);
		send(1'b1, a, v[7:0]);
		release_bus();
	endtask
	task automatic read_word(input logic [6:0] a, output logic [15:0] v);
		send(1'b0, a, 8'h00);
		release_bus();
		#1;
		v = readData;
	endtask
endmodule // sucal_host

// ==== verification/tb_sucal_bank.sv ====
// self-checking bench of the calibration bank
`timescale 1ns/1ps
module tb_sucal_bank;
	import sucal_pkg::*;
	logic               core_clk, rstn, sampleValid, flashStall, frameValid, frameWrite;
	logic               readValid, resultValid, samplingActive, rateOffsetClear;
	logic               flashWordValid, flashCommit, flashDone, cmdBusy;
	logic [6:0]         frameAddr;
	logic [7:0]         frameData;
	logic [3:0]         flashWordIndex;
	logic [15:0]        readData, flashWord, got, v;
	logic signed [15:0] raw [9];
	logic signed [15:0] res [6];
	logic [15:0]        regs [9];
	logic [15:0]        img [9];
	logic [31:0]        seed = 32'hc810;
	int                 n_mismatch = 0, cmp_count = 0, cyc = 0;
	////////////////////////////////////////////////////////////
	sucal_bank #(.FLASH_TIMEOUT_CYC(50)) i_dut
	(
		.rawAccelX(raw[0]), .rawAccelY(raw[1]), .rawAccelZ(raw[2]),
		.popAccelX(raw[3]), .popAccelY(raw[4]), .popAccelZ(raw[5]),
		.rawMagX(raw[6]), .rawMagY(raw[7]), .rawMagZ(raw[8]),
		.accelXResult(res[0]), .accelYResult(res[1]), .accelZResult(res[2]),
		.magXResult(res[3]), .magYResult(res[4]), .magZResult(res[5]),
		.*
	);
	sucal_host i_host (.*);
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [15:0] sat(input logic signed [31:0] x);
		return x > 32767 ? 16'h7fff : x < -32768 ? 16'h8000 : x[15:0];
	endfunction
	function automatic logic signed [31:0] sx(input logic [15:0] o);
		return {{18{o[13]}}, o[13:0]};
	endfunction
	function automatic logic [15:0] ea(input int i, input logic pop);
		return sat(raw[i] + sx(regs[i]) + (pop ? raw[i + 3] : 16'sh0));
	endfunction
	function automatic logic [15:0] em(input int i);
		return sat(((raw[i + 6] * $signed({1'b0, regs[i + 6][11:0]})) >>> 11) + sx(regs[i + 3]));
	endfunction
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
		cmp_count++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic check_regs();
		for (int i = 0; i < 9; i++)
		begin
			i_host.read_word(ADDR_ACCEL_X_OFFSET + 7'(2 * i), got);
			chk("register", regs[i], got);
			chk("readValid", 16'h0001, {15'h0, readValid});
		end
	endtask
	task automatic sample(input logic pop, input logic live);
		@(posedge core_clk);
		for (int i = 0; i < 9; i++)
		begin
			seed = lfsr(seed);
			raw[i] <= $signed(seed[15:0]) >>> seed[17:16];
		end
		sampleValid <= 1'b1;
		@(posedge core_clk);
		sampleValid <= 1'b0;
		#1;
		chk("resultValid", {15'h0, live}, {15'h0, resultValid});
		for (int i = 0; i < 3 && live; i++)
		begin
			chk("accel", ea(i, pop), res[i]);
			chk("mag", em(i), res[i + 3]);
		end
	endtask
	// the flag may fall at any edge, so it is polled clear of the edges
	task automatic wait_idle();
		#1;
		for (int n = 0; n < 200 && cmdBusy !== 1'b0; n++)
			#4;
		chk("cmdBusy", 16'h0, {15'h0, cmdBusy});
	endtask
	////////////////////////////////////////////////////////////
	initial
	begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	always @(posedge core_clk)
	begin
		cyc <= cyc + 1;
		if (flashWordValid)
			img[flashWordIndex] <= flashWord;
		if (cyc == 20000)
		begin
			n_mismatch++;
			close_out();
		end
	end
	initial
	begin
		rstn = 1'b0;
		sampleValid = 1'b0;
		flashStall = 1'b0;
		for (int i = 0; i < 9; i++)
		begin
			raw[i] = 16'sh0;
			regs[i] = (i < 3 || i > 5) ? 16'h0000 : 16'h0800;
		end
		repeat (4) @(posedge core_clk);
		rstn <= 1'b1;
		check_regs();
		i_host.read_word(7'h3a, got);
		chk("unmapped", 16'h0, got);
		for (int k = 0; k < 6; k++)
		begin
			for (int i = 0; i < 9; i++)
			begin
				seed = lfsr(seed);
				v = k == 0 ? (i == 7 ? 16'h0933 : i < 6 ? 16'h1ff6 : 16'h0800) : seed[15:0];
				if (k == 1)
					v = i < 6 ? 16'h2000 : 16'h0fff;
				i_host.write_word(ADDR_ACCEL_X_OFFSET + 7'(2 * i), v);
				regs[i] = v & (i < 6 ? 16'h3fff : 16'h0fff);
			end
			i_host.write_word(ADDR_MISC_CONTROL, {9'h0, k[0], 6'h0});
			i_host.read_word(ADDR_MISC_CONTROL, got);
			chk("misc", {9'h0, k[0], 6'h0}, got);
			check_regs();
			sample(k[0], 1'b1);
			sample(k[0], 1'b1);
		end
		i_host.write_word(ADDR_GLOBAL_COMMAND, 16'h0008);
		wait_idle();
		for (int i = 0; i < 9; i++)
			chk("flash", regs[i], img[i]);
		flashStall = 1'b1;
		i_host.write_word(ADDR_GLOBAL_COMMAND, 16'h0002);
		#1;
		chk("active", 16'h0, {15'h0, samplingActive});
		chk("rateClear", 16'h0001, {15'h0, rateOffsetClear});
		for (int i = 0; i < 6; i++)
			chk("cleared", 16'h0, res[i]);
		// a write while the restore runs must be dropped, so the offset stays zero
		i_host.write_word(ADDR_ACCEL_X_OFFSET, 16'h1234);
		sample(1'b0, 1'b0);
		wait_idle();
		chk("active", 16'h0001, {15'h0, samplingActive});
		for (int i = 0; i < 3; i++)
			regs[i] = 16'h0000;
		check_regs();
		for (int i = 0; i < 9; i++)
			chk("restored", regs[i], img[i]);
		i_host.write_word(ADDR_MISC_CONTROL, 16'h0040);
		sample(1'b1, 1'b1);
		close_out();
	end
endmodule // tb_sucal_bank
